/* fault_code_phase_loss_out.sv */
// fault code terminal output and phase loss protection with an ahb-lite register port
module fault_code_phase_loss_out #(
  parameter int unsigned IN_LOSS_CYCLES = fault_pkg::in_loss_cycles // 1 s persistence
) (
  input wire logic hclk, // system clock, 25 mhz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic trip_valid, // one-cycle trip event from the drive
  input wire logic [4:0] trip_kind, // kind of that trip
  input wire logic fault_reset, // one-cycle fault reset request
  input wire logic [3:0] assigned_signals, // terminal_function_assign outputs, bit3 first
  input wire logic out_phase_missing, // a load-side phase is lost
  input wire logic [2:0] in_phase_missing, // supply phases lost, bit0 first phase
  output logic code_bit_three, // first terminal, transistor on when high
  output logic code_bit_two, // second terminal
  output logic code_bit_one, // third terminal
  output logic code_bit_zero, // fourth terminal
  output logic fault_active, // a trip is latched
  output logic output_loss_trip, // output phase loss trip latched
  output logic input_loss_trip, // input phase loss trip latched
  output logic power_fail_decel, // request power-failure deceleration
  output logic output_shutoff // shut off output, no trip
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] code_output_select;
    logic output_loss_enable;
    logic input_loss_enable;
    logic power_fail_stop_select;
    logic fault;
    logic [3:0] code;
    logic out_trip;
    logic in_trip;
    logic decel;
    logic shutoff;
    logic [3:0] term;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic readyout;
    logic resp;
  } blk_state_t;

  blk_state_t st_r;
  blk_state_t st_nxt;

  logic loss_expired;
  logic one_phase_lost;
  logic first_two_lost;
  logic addr_phase;
  logic sw_clear;
  logic new_trip;
  logic [3:0] new_code;
  logic latch_open;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // trip kind to fault code; unknown kinds fall to the catch-all code
  function automatic logic [3:0] kind_to_code(input logic [4:0] kind);
    logic [3:0] c;
    c = fault_pkg::code_other;
    unique case (kind)
      fault_pkg::kind_accel_oc: c = 4'h1;
      fault_pkg::kind_const_oc: c = 4'h2;
      fault_pkg::kind_decel_oc: c = 4'h3;
      fault_pkg::kind_ov1,
      fault_pkg::kind_ov2,
      fault_pkg::kind_ov3: c = 4'h4;
      fault_pkg::kind_motor_thermal: c = 4'h5;
      fault_pkg::kind_transistor_thermal: c = 4'h6;
      fault_pkg::kind_power_fail: c = 4'h7;
      fault_pkg::kind_undervoltage: c = 4'h8;
      fault_pkg::kind_fin_overheat: c = 4'h9;
      fault_pkg::kind_brake: c = 4'ha;
      fault_pkg::kind_ground_fault: c = 4'hb;
      fault_pkg::kind_ext_thermal: c = 4'hc;
      fault_pkg::kind_stall_stop: c = 4'hd;
      fault_pkg::kind_option,
      fault_pkg::kind_comm_option: c = 4'he;
      default: c = fault_pkg::code_other;
    endcase
    return c;
  endfunction

  // terminal pattern for a selection, latched fault and code
  function automatic logic [3:0] term_value(input logic [1:0] sel, input logic flt,
                                            input logic [3:0] code, input logic [3:0] asg);
    logic [3:0] v;
    v = asg;
    unique case (sel)
      fault_pkg::sel_none: v = asg;
      fault_pkg::sel_always: v = flt ? code : fault_pkg::code_normal;
      fault_pkg::sel_on_fault: v = flt ? code : asg;
      default: v = asg;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // input phase loss persistence
  // ----------------------------------------------------------------

  // the first two phases lost together is handled by shutoff, not by the timer
  assign first_two_lost = in_phase_missing[0] & in_phase_missing[1];
  assign one_phase_lost = (|in_phase_missing) & ~first_two_lost;

  persist_timer u_in_loss_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(one_phase_lost & st_r.input_loss_enable),
    .limit(IN_LOSS_CYCLES),
    .expired(loss_expired)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------

  // a transfer is accepted on a ready cycle with nonseq or seq
  assign addr_phase = hsel & hready & htrans[1];

  // write of the clear bit acts like the fault reset input
  assign sw_clear = st_r.wr_pend && (st_r.wr_addr == fault_pkg::clear_addr) &&
                    hwdata[fault_pkg::clr_bit];

  // the latch takes a new trip when empty or being cleared this cycle: set wins over clear
  assign latch_open = ~st_r.fault | fault_reset | sw_clear;

  // ----------------------------------------------------------------
  // trip sources
  // ----------------------------------------------------------------
  always_comb begin
    new_trip = 1'b0;
    new_code = fault_pkg::code_other;
    if (trip_valid) begin
      new_trip = 1'b1;
      new_code = kind_to_code(trip_kind);
    end else if (out_phase_missing && st_r.output_loss_enable) begin
      new_trip = 1'b1;
      new_code = fault_pkg::code_other;
    end else if (loss_expired && !st_r.power_fail_stop_select) begin
      new_trip = 1'b1;
      new_code = fault_pkg::code_other;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.readyout = 1'b1; // zero wait states
    st_nxt.resp = 1'b0; // always okay

    // register write lands in the data phase after its address phase
    st_nxt.wr_pend = addr_phase & hwrite;
    if (addr_phase) begin
      st_nxt.wr_addr = haddr[7:0];
    end
    if (st_r.wr_pend && st_r.wr_addr == fault_pkg::ctrl_addr) begin
      // selection 3 is not a legal setting, so such a write keeps the old one
      if (hwdata[fault_pkg::sel_lsb +: 2] != 2'h3) begin
        st_nxt.code_output_select = hwdata[fault_pkg::sel_lsb +: 2];
      end
      st_nxt.output_loss_enable = hwdata[fault_pkg::out_en_bit];
      st_nxt.input_loss_enable = hwdata[fault_pkg::in_en_bit];
      st_nxt.power_fail_stop_select = hwdata[fault_pkg::pfs_bit];
    end

    // fault reset clears the latch; a trip in the same cycle still lands
    if (fault_reset || sw_clear) begin
      st_nxt.fault = 1'b0;
      st_nxt.code = fault_pkg::code_normal;
      st_nxt.out_trip = 1'b0;
      st_nxt.in_trip = 1'b0;
    end

    // first trip wins and its code holds until reset
    if (new_trip && latch_open) begin
      st_nxt.fault = 1'b1;
      st_nxt.code = new_code;
    end
    if (out_phase_missing && st_r.output_loss_enable && !trip_valid && latch_open) begin
      st_nxt.out_trip = 1'b1;
    end
    if (loss_expired && !st_r.power_fail_stop_select && !trip_valid && latch_open &&
        !(out_phase_missing && st_r.output_loss_enable)) begin
      st_nxt.in_trip = 1'b1;
    end

    // power-failure stop takes the phase loss as a deceleration request
    st_nxt.decel = loss_expired & st_r.power_fail_stop_select;
    st_nxt.shutoff = first_two_lost;

    // terminals follow the latched state one cycle later
    st_nxt.term = term_value(st_r.code_output_select, st_r.fault, st_r.code,
                             assigned_signals);

    // read data is registered from the address phase
    st_nxt.rdata = 32'h0000_0000;
    if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        fault_pkg::ctrl_addr: begin
          st_nxt.rdata[fault_pkg::sel_lsb +: 2] = st_r.code_output_select;
          st_nxt.rdata[fault_pkg::out_en_bit] = st_r.output_loss_enable;
          st_nxt.rdata[fault_pkg::in_en_bit] = st_r.input_loss_enable;
          st_nxt.rdata[fault_pkg::pfs_bit] = st_r.power_fail_stop_select;
        end
        fault_pkg::status_addr: begin
          st_nxt.rdata[fault_pkg::st_code_lsb +: 4] = st_r.code;
          st_nxt.rdata[fault_pkg::st_fault_bit] = st_r.fault;
          st_nxt.rdata[fault_pkg::st_out_trip_bit] = st_r.out_trip;
          st_nxt.rdata[fault_pkg::st_in_trip_bit] = st_r.in_trip;
          st_nxt.rdata[fault_pkg::st_decel_bit] = st_r.decel;
          st_nxt.rdata[fault_pkg::st_shutoff_bit] = st_r.shutoff;
        end
        default: st_nxt.rdata = 32'h0000_0000; // unmapped and clear read zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.code_output_select <= fault_pkg::sel_rst;
      st_r.output_loss_enable <= fault_pkg::out_en_rst;
      st_r.input_loss_enable <= fault_pkg::in_en_rst;
      st_r.power_fail_stop_select <= fault_pkg::pfs_rst;
      st_r.readyout <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hrdata = st_r.rdata;
  assign hreadyout = st_r.readyout;
  assign hresp = st_r.resp;
  assign code_bit_three = st_r.term[3];
  assign code_bit_two = st_r.term[2];
  assign code_bit_one = st_r.term[1];
  assign code_bit_zero = st_r.term[0];
  assign fault_active = st_r.fault;
  assign output_loss_trip = st_r.out_trip;
  assign input_loss_trip = st_r.in_trip;
  assign power_fail_decel = st_r.decel;
  assign output_shutoff = st_r.shutoff;

endmodule // fault_code_phase_loss_out

/* fault_pkg.sv */
// constants, field layout and fault kinds shared by the fault reporting block
package fault_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] status_addr = 8'h04;
  localparam logic [7:0] clear_addr = 8'h08;

  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int sel_lsb = 0;
  localparam int out_en_bit = 2;
  localparam int in_en_bit = 3;
  localparam int pfs_bit = 4;
  localparam logic [1:0] sel_rst = 2'h0;
  localparam logic out_en_rst = 1'b1;
  localparam logic in_en_rst = 1'b0;
  localparam logic pfs_rst = 1'b0;

  // ----------------------------------------------------------------
  // status word fields
  // ----------------------------------------------------------------
  localparam int st_code_lsb = 0;
  localparam int st_fault_bit = 4;
  localparam int st_out_trip_bit = 5;
  localparam int st_in_trip_bit = 6;
  localparam int st_decel_bit = 7;
  localparam int st_shutoff_bit = 8;
  localparam int clr_bit = 0;

  // ----------------------------------------------------------------
  // code output selection values
  // ----------------------------------------------------------------
  localparam logic [1:0] sel_none = 2'h0;
  localparam logic [1:0] sel_always = 2'h1;
  localparam logic [1:0] sel_on_fault = 2'h2;

  // ----------------------------------------------------------------
  // trip kinds reported on trip_kind
  // ----------------------------------------------------------------
  localparam logic [4:0] kind_accel_oc = 5'h01;
  localparam logic [4:0] kind_const_oc = 5'h02;
  localparam logic [4:0] kind_decel_oc = 5'h03;
  localparam logic [4:0] kind_ov1 = 5'h04;
  localparam logic [4:0] kind_ov2 = 5'h05;
  localparam logic [4:0] kind_ov3 = 5'h06;
  localparam logic [4:0] kind_motor_thermal = 5'h07;
  localparam logic [4:0] kind_transistor_thermal = 5'h08;
  localparam logic [4:0] kind_power_fail = 5'h09;
  localparam logic [4:0] kind_undervoltage = 5'h0a;
  localparam logic [4:0] kind_fin_overheat = 5'h0b;
  localparam logic [4:0] kind_brake = 5'h0c;
  localparam logic [4:0] kind_ground_fault = 5'h0d;
  localparam logic [4:0] kind_ext_thermal = 5'h0e;
  localparam logic [4:0] kind_stall_stop = 5'h0f;
  localparam logic [4:0] kind_option = 5'h10;
  localparam logic [4:0] kind_comm_option = 5'h11;

  // ----------------------------------------------------------------
  // fault codes
  // ----------------------------------------------------------------
  localparam logic [3:0] code_normal = 4'h0;
  localparam logic [3:0] code_other = 4'hf;

  // ----------------------------------------------------------------
  // input phase loss persistence
  // ----------------------------------------------------------------
  localparam int unsigned clk_hz = 25_000_000;
  localparam int unsigned in_loss_ms = 1000;
  localparam int unsigned in_loss_cycles = clk_hz / 1000 * in_loss_ms;

endpackage

/* persist_timer.sv */
// counts cycles of a continuous condition and flags when the limit is reached
module persist_timer (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic run, // condition present this cycle
  input wire logic [31:0] limit, // cycles the condition must persist
  output logic expired // condition held for limit cycles
);

  typedef struct packed {
    logic [31:0] cnt;
    logic expired;
  } timer_state_t;

  timer_state_t st_r;
  timer_state_t st_nxt;

  // any gap in the condition restarts the count from zero
  always_comb begin
    st_nxt = st_r;
    if (!run) begin
      st_nxt.cnt = 32'h0000_0000;
      st_nxt.expired = 1'b0;
    end else if (st_r.cnt + 32'h0000_0001 >= limit) begin
      st_nxt.expired = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h0000_0001;
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired = st_r.expired;

endmodule // persist_timer

/* fault_checker.sv */
// concurrent checks on the fault code terminals and phase loss outputs
module fault_checker (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic hready, // bus ready
  input wire logic [31:0] hwdata, // write data
  input wire logic trip_valid, // trip event
  input wire logic fault_reset, // fault reset pulse
  input wire logic [3:0] assigned_signals, // normal terminal signals
  input wire logic out_phase_missing, // load-side phase lost
  input wire logic [2:0] in_phase_missing, // supply phases lost
  input wire logic code_bit_three, // first terminal
  input wire logic code_bit_two, // second terminal
  input wire logic code_bit_one, // third terminal
  input wire logic code_bit_zero, // fourth terminal
  input wire logic fault_active, // fault latched
  input wire logic output_loss_trip, // output loss trip
  input wire logic input_loss_trip, // input loss trip
  input wire logic power_fail_decel, // deceleration request
  input wire logic output_shutoff // output shut off
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic [1:0] sel_q;
  logic [1:0] live_q;
  logic out_en_q;
  logic wr_q;
  logic hsel_q;
  wire [3:0] terms = {code_bit_three, code_bit_two, code_bit_one, code_bit_zero};
  wire two_lost = in_phase_missing[0] & in_phase_missing[1];
  wire any_lost = |in_phase_missing;
  // no clear can land this cycle: no reset pulse and no data phase
  wire quiet = !fault_reset && !hsel_q;
  // shadow of the control word; a selection of 3 is ignored like in the design
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_q <= fault_pkg::sel_rst;
      out_en_q <= fault_pkg::out_en_rst;
      wr_q <= 1'b0;
      hsel_q <= 1'b0;
      live_q <= 2'h0;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite && haddr == {24'h0, fault_pkg::ctrl_addr};
      hsel_q <= hsel;
      live_q <= {live_q[0], 1'b1};
      if (wr_q) begin
        out_en_q <= hwdata[fault_pkg::out_en_bit];
        if (hwdata[1:0] != 2'h3) begin
          sel_q <= hwdata[1:0];
        end
      end
    end
  end
  a_trip_latch: assert property (trip_valid && !fault_active |=> fault_active)
    else $error("trip not latched");
  a_fault_hold: assert property (fault_active && quiet |=> fault_active)
    else $error("fault dropped without reset");
  a_out_trip_on: assert property (live_q[1] && out_phase_missing && out_en_q && !fault_active
    |=> output_loss_trip)
    else $error("output loss not tripped");
  a_out_trip_off: assert property ($rose(output_loss_trip) |-> $past(out_en_q)
    && $past(out_phase_missing))
    else $error("output loss trip without cause");
  a_shutoff_follow: assert property (live_q[1] |-> output_shutoff == $past(two_lost))
    else $error("shutoff does not follow phases");
  a_in_trip_fault: assert property ($rose(input_loss_trip) |-> fault_active
    && !power_fail_decel)
    else $error("input loss trip without fault");
  a_decel_cause: assert property ($rose(power_fail_decel) |-> $past(any_lost))
    else $error("deceleration without phase loss");
  a_sel_none: assert property (live_q[1] && $past(sel_q) == fault_pkg::sel_none
    |-> terms == $past(assigned_signals))
    else $error("terminals not assigned at selection 0");
  a_sel_idle: assert property (live_q[1] && $past(sel_q) == fault_pkg::sel_on_fault
    && !$past(fault_active) |-> terms == $past(assigned_signals))
    else $error("terminals not assigned while normal");
  a_sel_zero: assert property (live_q[1] && $past(sel_q) == fault_pkg::sel_always
    && !$past(fault_active) |-> terms == fault_pkg::code_normal)
    else $error("code not zero while normal");
  a_code_hold: assert property (live_q[1] && $past(sel_q, 2) != 2'h0 && $past(sel_q) != 2'h0
    && $past(fault_active, 2) && $past(fault_active) && $past(quiet, 2)
    |-> $stable(terms))
    else $error("code changed during fault");
endmodule // fault_checker
bind fault_code_phase_loss_out fault_checker chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .trip_valid, .fault_reset, .assigned_signals, .out_phase_missing,
  .in_phase_missing, .code_bit_three, .code_bit_two, .code_bit_one, .code_bit_zero,
  .fault_active, .output_loss_trip, .input_loss_trip, .power_fail_decel, .output_shutoff);

/* code_reader.sv */
// controller model that reads the four fault code terminals each clock
module code_reader (
  input wire logic hclk, // clock
  input wire logic t3, // first terminal
  input wire logic t2, // second terminal
  input wire logic t1, // third terminal
  input wire logic t0, // fourth terminal
  output logic [3:0] code_seen // last code read
);
  timeunit 1ns;
  timeprecision 1ns;
  // transistor on reads as 1, first terminal lands in the msb
  always_ff @(posedge hclk) begin
    code_seen <= {t3, t2, t1, t0};
  end
endmodule // code_reader

/* testbench.sv */
// self-checking bench for the fault code and phase loss block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned loss_n = 20;
  logic hclk, hresetn, hsel, hwrite, trip_valid, fault_reset, out_miss;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [4:0] kd;
  logic [3:0] asg, seen;
  logic [2:0] in_miss;
  logic hreadyout, hresp, b3, b2, b1, b0, flt, otrip, itrip, decel, shut;
  int mismatches = 0;
  int checks_done = 0;
  fault_code_phase_loss_out #(.IN_LOSS_CYCLES(loss_n)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .trip_valid(trip_valid), .trip_kind(kd), .fault_reset(fault_reset), .assigned_signals(asg),
    .out_phase_missing(out_miss), .in_phase_missing(in_miss), .code_bit_three(b3),
    .code_bit_two(b2), .code_bit_one(b1), .code_bit_zero(b0), .fault_active(flt),
    .output_loss_trip(otrip), .input_loss_trip(itrip), .power_fail_decel(decel),
    .output_shutoff(shut));
  code_reader reader_u (.hclk(hclk), .t3(b3), .t2(b2), .t1(b1), .t0(b0), .code_seen(seen));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] exp_code(input logic [4:0] k);
    if (k == 5'h00) return 4'hf;
    if (k <= fault_pkg::kind_decel_oc) return k[3:0];
    if (k <= fault_pkg::kind_ov3) return 4'h4;
    if (k <= fault_pkg::kind_stall_stop) return k[3:0] - 4'h2;
    if (k <= fault_pkg::kind_comm_option) return 4'he;
    return fault_pkg::code_other;
  endfunction
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // one edge with hready high, bounded so a stuck slave ends the run
  task automatic rdy;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      conclude();
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(what, q, exp);
    check("hresp", 32'(hresp), 32'h0);
  endtask
  // trips and resets are one-cycle pulses; the code reaches the reader 3 edges later
  task automatic trip(input logic [4:0] k);
    @(posedge hclk);
    trip_valid <= 1'b1;
    kd <= k;
    @(posedge hclk);
    trip_valid <= 1'b0;
    tick(3);
  endtask
  task automatic clr;
    @(posedge hclk);
    fault_reset <= 1'b1;
    @(posedge hclk);
    fault_reset <= 1'b0;
    tick(3);
  endtask
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, trip_valid, fault_reset, out_miss} = '0;
    {haddr, hwdata, htrans, kd, asg, in_miss} = '0;
    void'($urandom(32'h2698a3b7));
    tick(20);
    hresetn <= 1'b1;
    rdc("ctrl", fault_pkg::ctrl_addr, 32'h4);
    rdc("status", fault_pkg::status_addr, 32'h0);
    rdc("unmapped", 8'h0c, 32'h0);
    rdc("clear", fault_pkg::clear_addr, 32'h0);
    // selection 0 ignores a fault; clearing through the register
    asg <= 4'($urandom);
    trip(fault_pkg::kind_brake);
    check("terms sel0", seen, asg);
    rdc("status brake", fault_pkg::status_addr, 32'h1a);
    bus(fault_pkg::clear_addr, 1'b1, 32'h1);
    tick(3);
    rdc("status cleared", fault_pkg::status_addr, 32'h0);
    // every kind, then random undefined ones, under both code selections
    for (int s = 1; s <= 2; s++) begin
      bus(fault_pkg::ctrl_addr, 1'b1, 32'(s) | 32'h4);
      for (int k = 0; k < 24; k++) begin
        asg <= 4'($urandom);
        trip((k < 18) ? 5'(k) : 5'($urandom_range(31, 18)));
        check("code", seen, exp_code(kd));
        q = 32'(exp_code(kd));
        trip(5'(k + 1));
        check("held", seen, q);
        clr();
        check("idle", seen, (s == 1) ? 4'h0 : asg);
      end
    end
    // a clear and a new trip in one cycle: the new trip is latched
    trip(fault_pkg::kind_brake);
    @(posedge hclk);
    fault_reset <= 1'b1;
    trip_valid <= 1'b1;
    kd <= fault_pkg::kind_stall_stop;
    @(posedge hclk);
    fault_reset <= 1'b0;
    trip_valid <= 1'b0;
    tick(3);
    check("set wins", seen, 4'hd);
    clr();
    bus(fault_pkg::ctrl_addr, 1'b1, 32'h7);
    rdc("ctrl sel3", fault_pkg::ctrl_addr, 32'h6);
    // output phase loss with the enable on and off
    bus(fault_pkg::ctrl_addr, 1'b1, 32'h4);
    out_miss <= 1'b1;
    tick(3);
    check("out trip", otrip, 1'b1);
    rdc("status out", fault_pkg::status_addr, 32'h3f);
    out_miss <= 1'b0;
    clr();
    bus(fault_pkg::ctrl_addr, 1'b1, 32'h0);
    out_miss <= 1'b1;
    tick(10);
    check("out off", {otrip, flt}, 2'h0);
    out_miss <= 1'b0;
    // input phase loss: a gap restarts the count
    bus(fault_pkg::ctrl_addr, 1'b1, 32'h8);
    in_miss <= 3'h4;
    tick(15);
    in_miss <= 3'h0;
    tick(1);
    in_miss <= 3'h4;
    tick(15);
    check("in early", itrip, 1'b0);
    tick(10);
    check("in trip", {itrip, flt}, 2'h3);
    in_miss <= 3'h0;
    clr();
    bus(fault_pkg::ctrl_addr, 1'b1, 32'h18);
    in_miss <= 3'h1;
    tick(loss_n + 5);
    check("decel", {decel, itrip}, 2'h2);
    in_miss <= 3'h0;
    tick(3);
    check("decel off", decel, 1'b0);
    bus(fault_pkg::ctrl_addr, 1'b1, 32'h8);
    in_miss <= 3'h3;
    tick(loss_n + 5);
    check("shutoff", {shut, itrip}, 2'h2);
    in_miss <= 3'h0;
    tick(3);
    check("shutoff off", shut, 1'b0);
    bus(fault_pkg::ctrl_addr, 1'b1, 32'h0);
    in_miss <= 3'h2;
    tick(loss_n + 5);
    check("in off", itrip, 1'b0);
    in_miss <= 3'h0;
    conclude();
  end
endmodule // testbench
